//--- core/mon_pkg.sv
// Constants and field layouts for the monitor result and alert registers, and the serial slave state encodings.
package mon_pkg;

	localparam logic [7:0]  REG_BUS    = 8'h02;
	localparam logic [7:0]  REG_PWR    = 8'h03;
	localparam logic [7:0]  REG_CUR    = 8'h04;
	localparam logic [7:0]  REG_CAL    = 8'h05;
	localparam logic [7:0]  REG_MASK   = 8'h06;
	localparam logic [7:0]  REG_LIMIT  = 8'h07;

	localparam logic [15:0] RST_WORD   = 16'h0000;
	localparam logic [14:0] RST_BUS    = 15'h0000;
	localparam logic [14:0] RST_CAL    = 15'h0000;
	localparam logic [5:0]  RST_SEL    = 6'h00;
	localparam logic [6:0]  RST_ADDR   = 7'h40;

	// Select-field positions in the limit select register; index 0 is bit 10.
	localparam int MASK_SEL_MSB = 15;
	localparam int MASK_SEL_LSB = 10;
	localparam int MASK_AFF     = 4;
	localparam int MASK_CONVERSION_COMPLETE_FLAG    = 3;
	localparam int MASK_OVF     = 2;
	localparam int MASK_POL     = 1;
	localparam int MASK_LATCH   = 0;
	localparam int SEL_SH_OVER  = 5;
	localparam int SEL_SH_UNDER = 4;
	localparam int SEL_BUS_OVER = 3;
	localparam int SEL_BUS_UNDR = 2;
	localparam int SEL_PWR_OVER = 1;
	localparam int SEL_CONV     = 0;

	// Current scaling: product of shunt and calibration codes, shifted down.
	localparam int CUR_SHIFT        = 11;
	localparam int CUR_MAX          = 32767;
	localparam int CUR_MIN          = -32768;
	// Bus count weight in microvolts and power weight in current counts.
	localparam int BUS_LSB_UV       = 1250;
	localparam int POWER_LSB_FACTOR = 25;
	localparam logic [30:0] POWER_DIV = 31'(POWER_LSB_FACTOR * 1000000 / BUS_LSB_UV);

	typedef enum logic [5:0]
	{
		SL_IDLE   = 6'h01,
		SL_RECV   = 6'h02,
		SL_AKDRV  = 6'h04,
		SL_AKHOLD = 6'h08,
		SL_SEND   = 6'h10,
		SL_MACK   = 6'h20
	} mon_sl_st_t;

endpackage : mon_pkg

//--- core/mon_math.sv
// Two-stage arithmetic unit that derives current and power results.
`timescale 1ns/1ps
module mon_math
	import mon_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Operands, taken on start
	input  wire logic        start_in,
	input  wire logic [15:0] shunt_in,
	input  wire logic [14:0] bus_in,
	input  wire logic [14:0] cal_in,
	// Results
	output logic             done_out,
	output logic      [15:0] cur_out,
	output logic      [15:0] pwr_out,
	output logic             ovf_out
);

	generate
		if (POWER_DIV == 31'h00000000)
		begin : g_bad_div
			$error("power divider must be nonzero");
		end
	endgenerate

	function automatic logic [15:0] mag16(input logic [15:0] v);
		return v[15] ? 16'(~v + 16'h0001) : v;
	endfunction : mag16

	logic        v1_r,  v1_nxt;
	logic        done_r, done_nxt;
	logic [15:0] cur_r, cur_nxt;
	logic [15:0] pwr_r, pwr_nxt;
	logic [14:0] bus_r, bus_nxt;
	logic        ovf_r, ovf_nxt;
	logic signed [31:0] prod;
	logic signed [31:0] scaled;
	logic [30:0] pprod;
	logic [30:0] pquot;

	always_comb
	begin
		v1_nxt   = start_in;
		done_nxt = v1_r;
		cur_nxt  = cur_r;
		pwr_nxt  = pwr_r;
		bus_nxt  = bus_r;
		ovf_nxt  = ovf_r;
		prod     = $signed(shunt_in) * $signed({1'b0, cal_in});
		scaled   = prod >>> CUR_SHIFT;
		pprod    = 31'({15'h0000, mag16(cur_r)} * {16'h0000, bus_r});
		pquot    = pprod / POWER_DIV;
		if (start_in)
		begin
			bus_nxt = bus_in;
			ovf_nxt = 1'b0;
			if (scaled > CUR_MAX)
			begin
				cur_nxt = 16'h7FFF;
				ovf_nxt = 1'b1;
			end
			else if (scaled < CUR_MIN)
			begin
				cur_nxt = 16'h8000;
				ovf_nxt = 1'b1;
			end
			else
			begin
				cur_nxt = scaled[15:0];
			end
		end
		if (v1_r)
		begin
			pwr_nxt = pquot[15:0];
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			v1_r   <= 1'b0;
			done_r <= 1'b0;
			cur_r  <= RST_WORD;
			pwr_r  <= RST_WORD;
			bus_r  <= RST_BUS;
			ovf_r  <= 1'b0;
		end
		else
		begin
			v1_r   <= v1_nxt;
			done_r <= done_nxt;
			cur_r  <= cur_nxt;
			pwr_r  <= pwr_nxt;
			bus_r  <= bus_nxt;
			ovf_r  <= ovf_nxt;
		end
	end

	assign done_out = done_r;
	assign cur_out  = cur_r;
	assign pwr_out  = pwr_r;
	assign ovf_out  = ovf_r;

endmodule : mon_math

//--- core/mon_regs.sv
// Two-wire register slave with result, calibration, limit and alert logic.
`timescale 1ns/1ps
module mon_regs
	import mon_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = RST_ADDR
)
(
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_in,
	// Two-wire serial bus pins
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	// Completed measurement from the converter
	input  wire logic        conv_valid_in,
	input  wire logic [15:0] shunt_code_in,
	input  wire logic [15:0] bus_code_in,
	// Open-drain alert pin
	output logic             alert_out,
	output logic             alert_oe_out
);

	generate
		if (DEV_ADDR == 7'h00)
		begin : g_bad_addr
			$error("device address must not be the general call address");
		end
	endgenerate

	// Highest set select bit decides which comparison counts.
	function automatic logic fault_eval(
		input logic [5:0]  sel,
		input logic [15:0] shunt,
		input logic [14:0] bus,
		input logic [15:0] pwr,
		input logic [15:0] lim
	);
		logic r;
		r = 1'b0;
		if (sel[SEL_SH_OVER])
			r = $signed(shunt) > $signed(lim);
		else if (sel[SEL_SH_UNDER])
			r = $signed(shunt) < $signed(lim);
		else if (sel[SEL_BUS_OVER])
			r = {1'b0, bus} > lim;
		else if (sel[SEL_BUS_UNDR])
			r = {1'b0, bus} < lim;
		else if (sel[SEL_PWR_OVER])
			r = pwr > lim;
		return r;
	endfunction : fault_eval

	// Pin synchronisers; only the second stage and its delayed copy feed logic.
	logic scl_s1_r, scl_s2_r, scl_d_r;
	logic sda_s1_r, sda_s2_r, sda_d_r;

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r  <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r  <= 1'b1;
		end
		else
		begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_d_r  <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_d_r  <= sda_s2_r;
		end
	end

	logic scl_rise, scl_fall, bus_start, bus_stop;
	assign scl_rise  = scl_s2_r & ~scl_d_r;
	assign scl_fall  = ~scl_s2_r & scl_d_r;
	assign bus_start = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
	assign bus_stop  = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

	// Serial slave state.
	mon_sl_st_t  sl_r, sl_nxt;
	logic [2:0]  cnt_r, cnt_nxt;
	logic [7:0]  sh_r, sh_nxt;
	logic [1:0]  idx_r, idx_nxt;
	logic        rw_r, rw_nxt;
	logic        oe_r, oe_nxt;
	logic [7:0]  ptr_r, ptr_nxt;
	logic [7:0]  msb_r, msb_nxt;
	logic [15:0] word_r, word_nxt;
	logic        mack_r, mack_nxt;
	logic        wr_pulse_r, wr_pulse_nxt;
	logic [15:0] wdata_r, wdata_nxt;
	logic        rd_pulse_r, rd_pulse_nxt;
	logic        sda_lo_r;
	logic [15:0] rd_word;
	logic [7:0]  next_byte;

	always_comb
	begin
		sl_nxt       = sl_r;
		cnt_nxt      = cnt_r;
		sh_nxt       = sh_r;
		idx_nxt      = idx_r;
		rw_nxt       = rw_r;
		oe_nxt       = oe_r;
		ptr_nxt      = ptr_r;
		msb_nxt      = msb_r;
		word_nxt     = word_r;
		mack_nxt     = mack_r;
		wdata_nxt    = wdata_r;
		wr_pulse_nxt = 1'b0;
		rd_pulse_nxt = 1'b0;
		next_byte    = (idx_r == 2'd0) ? word_r[7:0] : word_r[15:8];
		if (bus_stop)
		begin
			sl_nxt = SL_IDLE;
			oe_nxt = 1'b0;
		end
		else if (bus_start)
		begin
			sl_nxt  = SL_RECV;
			cnt_nxt = 3'd0;
			idx_nxt = 2'd0;
			oe_nxt  = 1'b0;
		end
		else
		begin
			unique case (sl_r)
				SL_IDLE:
				begin
				end
				SL_RECV:
				begin
					if (scl_rise)
					begin
						sh_nxt  = {sh_r[6:0], sda_s2_r};
						cnt_nxt = cnt_r + 3'd1;
						if (cnt_r == 3'd7)
							sl_nxt = SL_AKDRV;
					end
				end
				SL_AKDRV:
				begin
					if (scl_fall)
					begin
						if (idx_r == 2'd0 && sh_r[7:1] != DEV_ADDR)
						begin
							sl_nxt = SL_IDLE;
						end
						else
						begin
							oe_nxt  = 1'b1;
							sl_nxt  = SL_AKHOLD;
							idx_nxt = (idx_r == 2'd3) ? 2'd3 : idx_r + 2'd1;
							if (idx_r == 2'd0)
								rw_nxt = sh_r[0];
							if (idx_r == 2'd1)
								ptr_nxt = sh_r;
							if (idx_r == 2'd2)
								msb_nxt = sh_r;
							if (idx_r == 2'd3)
							begin
								wr_pulse_nxt = 1'b1;
								wdata_nxt    = {msb_r, sh_r};
							end
						end
					end
				end
				SL_AKHOLD:
				begin
					if (scl_fall)
					begin
						cnt_nxt = 3'd0;
						if (rw_r)
						begin
							sl_nxt       = SL_SEND;
							word_nxt     = rd_word;
							rd_pulse_nxt = 1'b1;
							sh_nxt       = rd_word[15:8];
							oe_nxt       = ~rd_word[15];
							idx_nxt      = 2'd0;
						end
						else
						begin
							sl_nxt = SL_RECV;
							oe_nxt = 1'b0;
						end
					end
				end
				SL_SEND:
				begin
					if (scl_fall)
					begin
						cnt_nxt = cnt_r + 3'd1;
						if (cnt_r == 3'd7)
						begin
							oe_nxt = 1'b0;
							sl_nxt = SL_MACK;
						end
						else
						begin
							oe_nxt = ~sh_r[6];
							sh_nxt = {sh_r[6:0], 1'b0};
						end
					end
				end
				SL_MACK:
				begin
					if (scl_rise)
						mack_nxt = ~sda_s2_r;
					if (scl_fall)
					begin
						if (mack_r)
						begin
							sl_nxt  = SL_SEND;
							cnt_nxt = 3'd0;
							sh_nxt  = next_byte;
							oe_nxt  = ~next_byte[7];
							idx_nxt = ~idx_r;
						end
						else
						begin
							sl_nxt = SL_IDLE;
						end
					end
				end
				default:
				begin
					sl_nxt = SL_IDLE;
					oe_nxt = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			sl_r       <= SL_IDLE;
			cnt_r      <= 3'd0;
			sh_r       <= 8'h00;
			idx_r      <= 2'd0;
			rw_r       <= 1'b0;
			oe_r       <= 1'b0;
			ptr_r      <= 8'h00;
			msb_r      <= 8'h00;
			word_r     <= RST_WORD;
			mack_r     <= 1'b0;
			wr_pulse_r <= 1'b0;
			wdata_r    <= RST_WORD;
			rd_pulse_r <= 1'b0;
			sda_lo_r   <= 1'b0;
		end
		else
		begin
			sl_r       <= sl_nxt;
			cnt_r      <= cnt_nxt;
			sh_r       <= sh_nxt;
			idx_r      <= idx_nxt;
			rw_r       <= rw_nxt;
			oe_r       <= oe_nxt;
			ptr_r      <= ptr_nxt;
			msb_r      <= msb_nxt;
			word_r     <= word_nxt;
			mack_r     <= mack_nxt;
			wr_pulse_r <= wr_pulse_nxt;
			wdata_r    <= wdata_nxt;
			rd_pulse_r <= rd_pulse_nxt;
			sda_lo_r   <= 1'b0;
		end
	end

	assign sda_out    = sda_lo_r;
	assign sda_oe_out = oe_r;

	// Register, result and alert state.
	logic        busy_r, busy_nxt;
	logic        start_r, start_nxt;
	logic [15:0] pend_sh_r, pend_sh_nxt;
	logic [14:0] pend_bus_r, pend_bus_nxt;
	logic [14:0] bus_r, bus_nxt;
	logic [15:0] cur_r, cur_nxt;
	logic [15:0] pwr_r, pwr_nxt;
	logic [14:0] cal_r, cal_nxt;
	logic [5:0]  sel_r, sel_nxt;
	logic        pol_r, pol_nxt;
	logic        latch_r, latch_nxt;
	logic [15:0] lim_r, lim_nxt;
	logic        aff_r, aff_nxt;
	logic        conversion_complete_flag_r, conversion_complete_flag_nxt;
	logic        ovf_r, ovf_nxt;
	logic        alert_oe_r, alert_oe_nxt;
	logic        alert_lo_r;
	logic        m_done, m_ovf;
	logic [15:0] m_cur, m_pwr;

	mon_math u_math
	(
		.clk_in   (clk_in),
		.rst_in   (rst_in),
		.start_in (start_r),
		.shunt_in (pend_sh_r),
		.bus_in   (pend_bus_r),
		.cal_in   (cal_r),
		.done_out (m_done),
		.cur_out  (m_cur),
		.pwr_out  (m_pwr),
		.ovf_out  (m_ovf)
	);

	always_comb
	begin
		unique case (ptr_r)
			REG_BUS:   rd_word = {1'b0, bus_r};
			REG_PWR:   rd_word = pwr_r;
			REG_CUR:   rd_word = cur_r;
			REG_CAL:   rd_word = {1'b0, cal_r};
			REG_MASK:  rd_word = {sel_r, 5'h00, aff_r, conversion_complete_flag_r, ovf_r, pol_r, latch_r};
			REG_LIMIT: rd_word = lim_r;
			default:   rd_word = RST_WORD;
		endcase
	end

	always_comb
	begin
		busy_nxt     = busy_r;
		start_nxt    = 1'b0;
		pend_sh_nxt  = pend_sh_r;
		pend_bus_nxt = pend_bus_r;
		bus_nxt      = bus_r;
		cur_nxt      = cur_r;
		pwr_nxt      = pwr_r;
		cal_nxt      = cal_r;
		sel_nxt      = sel_r;
		pol_nxt      = pol_r;
		latch_nxt    = latch_r;
		lim_nxt      = lim_r;
		aff_nxt      = aff_r;
		conversion_complete_flag_nxt     = conversion_complete_flag_r;
		ovf_nxt      = ovf_r;
		// Upstream averages before presenting; a sample that lands while busy is dropped.
		if (conv_valid_in && !busy_r)
		begin
			pend_sh_nxt  = shunt_code_in;
			pend_bus_nxt = bus_code_in[14:0];
			busy_nxt     = 1'b1;
			start_nxt    = 1'b1;
		end
		if (rd_pulse_r && ptr_r == REG_MASK)
		begin
			conversion_complete_flag_nxt = 1'b0;
			ovf_nxt  = 1'b0;
			if (latch_r)
				aff_nxt = 1'b0;
		end
		if (wr_pulse_r)
		begin
			unique case (ptr_r)
				REG_CAL:   cal_nxt = wdata_r[14:0];
				REG_MASK:
				begin
					sel_nxt   = wdata_r[MASK_SEL_MSB:MASK_SEL_LSB];
					pol_nxt   = wdata_r[MASK_POL];
					latch_nxt = wdata_r[MASK_LATCH];
				end
				REG_LIMIT: lim_nxt = wdata_r;
				default:;
			endcase
		end
		// Completion sets flags after any clear above, so an event in the clearing cycle is never lost.
		if (m_done)
		begin
			busy_nxt  = 1'b0;
			bus_nxt   = pend_bus_r;
			cur_nxt   = m_cur;
			pwr_nxt   = m_pwr;
			conversion_complete_flag_nxt  = 1'b1;
			if (m_ovf)
				ovf_nxt = 1'b1;
			if (fault_eval(sel_r, pend_sh_r, pend_bus_r, m_pwr, lim_r))
				aff_nxt = 1'b1;
			else if (!latch_r)
				aff_nxt = 1'b0;
		end
		// Open drain: pulled low when active in normal polarity, when idle if inverted.
		alert_oe_nxt = (aff_nxt | (sel_nxt[SEL_CONV] & conversion_complete_flag_nxt)) ^ pol_nxt;
	end

	always_ff @(posedge clk_in)
	begin
		if (rst_in)
		begin
			busy_r     <= 1'b0;
			start_r    <= 1'b0;
			pend_sh_r  <= RST_WORD;
			pend_bus_r <= RST_BUS;
			bus_r      <= RST_BUS;
			cur_r      <= RST_WORD;
			pwr_r      <= RST_WORD;
			cal_r      <= RST_CAL;
			sel_r      <= RST_SEL;
			pol_r      <= 1'b0;
			latch_r    <= 1'b0;
			lim_r      <= RST_WORD;
			aff_r      <= 1'b0;
			conversion_complete_flag_r     <= 1'b0;
			ovf_r      <= 1'b0;
			alert_oe_r <= 1'b0;
			alert_lo_r <= 1'b0;
		end
		else
		begin
			busy_r     <= busy_nxt;
			start_r    <= start_nxt;
			pend_sh_r  <= pend_sh_nxt;
			pend_bus_r <= pend_bus_nxt;
			bus_r      <= bus_nxt;
			cur_r      <= cur_nxt;
			pwr_r      <= pwr_nxt;
			cal_r      <= cal_nxt;
			sel_r      <= sel_nxt;
			pol_r      <= pol_nxt;
			latch_r    <= latch_nxt;
			lim_r      <= lim_nxt;
			aff_r      <= aff_nxt;
			conversion_complete_flag_r     <= conversion_complete_flag_nxt;
			ovf_r      <= ovf_nxt;
			alert_oe_r <= alert_oe_nxt;
			alert_lo_r <= 1'b0;
		end
	end

	assign alert_out    = alert_lo_r;
	assign alert_oe_out = alert_oe_r;

endmodule : mon_regs

//--- dv/mon_regs_properties.sv
// Port-level properties of the monitor register block, bound to its top module.
`timescale 1ns/1ps
module mon_regs_properties
(
	// Clock and reset
	input wire logic        clk_in,
	input wire logic        rst_in,
	// Serial pins
	input wire logic        scl_in,
	input wire logic        sda_in,
	input wire logic        sda_out,
	input wire logic        sda_oe_out,
	// Measurement and alert pins
	input wire logic        conv_valid_in,
	input wire logic [15:0] shunt_code_in,
	input wire logic [15:0] bus_code_in,
	input wire logic        alert_out,
	input wire logic        alert_oe_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);

	sequence scl_high2;
		scl_in [*2];
	endsequence
	sequence conv_wait;
		conv_valid_in ##1 scl_in [*3];
	endsequence
	sequence stop_seen;
		scl_in && $rose(sda_in);
	endsequence

	alert_zero_a: assert property (alert_out == 1'b0) else $error("alert level not low");
	sda_zero_a: assert property (sda_out == 1'b0) else $error("data level not low");
	// Outside bus traffic only a conversion four edges back may move the alert pin.
	alert_rise_a: assert property ($rose(alert_oe_out) |-> $past(conv_valid_in, 4) || !scl_in)
		else $error("alert rose without cause");
	alert_fall_a: assert property ($fell(alert_oe_out) |-> $past(conv_valid_in, 4) || !scl_in)
		else $error("alert fell without cause");
	conv_quiet_a: assert property (conv_wait |-> $stable(alert_oe_out))
		else $error("alert moved before results");
	sda_hold_a: assert property (scl_high2 |-> $stable(sda_oe_out))
		else $error("data moved with clock high");
	sda_stop_a: assert property (stop_seen |-> !sda_oe_out)
		else $error("data held after stop");
	boot_quiet_a: assert property ($fell(rst_in) |-> (!alert_oe_out && !sda_oe_out) [*4])
		else $error("pins active after reset");
endmodule : mon_regs_properties

bind mon_regs mon_regs_properties mon_regs_properties_i
(
	.clk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out, .conv_valid_in,
	.shunt_code_in, .bus_code_in, .alert_out, .alert_oe_out
);

//--- dv/mon_host.sv
// Two-wire bus host model driving the serial clock and pulling the data line.
`timescale 1ns/1ps
module mon_host
(
	// Clock and line level
	input  wire logic clk_in,
	input  wire logic sda_in,
	// Serial pins
	output logic      scl_out,
	output logic      sda_low_out
);
	initial
	begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge clk_in);
		#10;
	endtask : hold

	// Data moves only with the clock low, so no false frame edge is ever seen.
	task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
		for (int i = 8; i >= 0; i--)
		begin
			scl_out = 1'b0;
			hold(4);
			sda_low_out = !tx[i];
			hold(4);
			scl_out = 1'b1;
			repeat (4) @(posedge clk_in);
			rx[i] = sda_in;
			hold(4);
		end
	endtask : xfer

	// Start is a falling data edge with the clock high, stop a rising one.
	task automatic frame_edge(input logic low_a, input logic low_b);
		scl_out = 1'b0;
		hold(4);
		sda_low_out = low_a;
		hold(4);
		scl_out = 1'b1;
		hold(8);
		sda_low_out = low_b;
		hold(8);
	endtask : frame_edge
endmodule : mon_host

//--- dv/testbench.sv
// Self-checking bench for the monitor register block and its serial host.
`timescale 1ns/1ps
module testbench
	import mon_pkg::*;
;
	localparam logic [6:0] DEV = 7'h40;
	logic        clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        scl_in;
	logic        sda_low;
	logic        sda_out;
	logic        sda_oe_out;
	logic        conv_valid_in = 1'b0;
	logic [15:0] shunt_code_in = 16'h0000;
	logic [15:0] bus_code_in = 16'h0000;
	logic        alert_out;
	logic        alert_oe_out;
	logic [15:0] rd_val;
	int          n_mismatch = 0;
	int          comparisons = 0;
	// The data line has a pull-up: it is low only while some party pulls it.
	wire logic   sda_in = !(sda_low || (sda_oe_out && !sda_out));

	always #50 clk_in = !clk_in;

	mon_regs #(.DEV_ADDR(DEV)) mon_regs_i
	(
		.clk_in, .rst_in, .scl_in, .sda_in, .sda_out, .sda_oe_out,
		.conv_valid_in, .shunt_code_in, .bus_code_in, .alert_out, .alert_oe_out
	);
	mon_host mon_host_i (.clk_in, .sda_in, .scl_out(scl_in), .sda_low_out(sda_low));

	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task automatic test_done();
		$display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done

	task automatic wr(input logic [7:0] ptr, input logic [15:0] d);
		logic [8:0] rx;
		mon_host_i.frame_edge(1'b0, 1'b1);
		mon_host_i.xfer({DEV, 1'b0, 1'b1}, rx);
		mon_host_i.xfer({ptr, 1'b1}, rx);
		mon_host_i.xfer({d[15:8], 1'b1}, rx);
		mon_host_i.xfer({d[7:0], 1'b1}, rx);
		mon_host_i.frame_edge(1'b1, 1'b0);
	endtask : wr

	task automatic rd(input logic [7:0] ptr, output logic [15:0] d);
		logic [8:0] hi;
		logic [8:0] lo;
		mon_host_i.frame_edge(1'b0, 1'b1);
		mon_host_i.xfer({DEV, 1'b0, 1'b1}, hi);
		mon_host_i.xfer({ptr, 1'b1}, hi);
		mon_host_i.frame_edge(1'b0, 1'b1);
		mon_host_i.xfer({DEV, 1'b1, 1'b1}, hi);
		mon_host_i.xfer(9'h1FE, hi);
		mon_host_i.xfer(9'h1FF, lo);
		mon_host_i.frame_edge(1'b1, 1'b0);
		d = {hi[8:1], lo[8:1]};
	endtask : rd

	task automatic conv(input logic [15:0] sh, input logic [15:0] bv);
		@(posedge clk_in);
		#10;
		conv_valid_in = 1'b1;
		shunt_code_in = sh;
		bus_code_in = bv;
		@(posedge clk_in);
		#10;
		conv_valid_in = 1'b0;
		repeat (6) @(posedge clk_in);
		#10;
	endtask : conv

	function automatic logic [15:0] cur_of(input logic [15:0] sh, input logic [14:0] cal);
		return 16'((longint'(signed'(sh)) * longint'(cal)) >>> CUR_SHIFT);
	endfunction : cur_of

	function automatic logic [15:0] pwr_of(input logic [15:0] c, input logic [14:0] b);
		longint m;
		m = longint'(signed'(c));
		if (m < 0)
			m = -m;
		return 16'(m * longint'(b) / longint'(POWER_DIV));
	endfunction : pwr_of

	task automatic t_reset();
		for (int p = 2; p < 8; p++)
		begin
			rd(8'(p), rd_val);
			chk("reset value", 16'h0000, rd_val);
		end
		$display("test reset values done");
	endtask : t_reset

	task automatic t_results();
		logic [15:0] sh;
		logic [15:0] c;
		wr(REG_CAL, 16'h9000);
		rd(REG_CAL, rd_val);
		chk("calibration", 16'h1000, rd_val);
		for (int i = 0; i < 2; i++)
		begin
			sh = i ? 16'hF800 : 16'h0800;
			c = cur_of(sh, 15'h1000);
			conv(sh, 16'hFFFF);
			rd(REG_BUS, rd_val);
			chk("bus result", 16'h7FFF, rd_val);
			rd(REG_CUR, rd_val);
			chk("current", c, rd_val);
			rd(REG_PWR, rd_val);
			chk("power", pwr_of(c, 15'h7FFF), rd_val);
		end
		for (int p = 2; p < 5; p++)
			wr(8'(p), 16'h1234);
		wr(8'h0F, 16'h1234);
		rd(8'h0F, rd_val);
		chk("unmapped", 16'h0000, rd_val);
		rd(REG_BUS, rd_val);
		chk("bus kept", 16'h7FFF, rd_val);
		rd(REG_CUR, rd_val);
		chk("current kept", c, rd_val);
		rd(REG_PWR, rd_val);
		chk("power kept", pwr_of(c, 15'h7FFF), rd_val);
		$display("test results done");
	endtask : t_results

	task automatic t_limits();
		logic [15:0] sel [6] = '{16'h8000, 16'h4000, 16'h2000, 16'h1000, 16'h0800, 16'hC000};
		logic        hit [6] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
		wr(REG_LIMIT, 16'h0100);
		for (int k = 0; k < 6; k++)
		begin
			wr(REG_MASK, sel[k]);
			conv(16'h0200, 16'h2000);
			chk("alert on high input", {15'h0000, hit[k]}, {15'h0000, alert_oe_out});
			conv(16'h0080, 16'h0080);
			chk("alert on low input", {15'h0000, !hit[k]}, {15'h0000, alert_oe_out});
		end
		$display("test limit select done");
	endtask : t_limits

	task automatic t_latch();
		wr(REG_MASK, 16'h2001);
		conv(16'h0200, 16'h2000);
		conv(16'h0080, 16'h0080);
		chk("latched alert", 16'h0001, {15'h0000, alert_oe_out});
		rd(REG_MASK, rd_val);
		chk("select and flags", 16'h2019, rd_val);
		chk("released alert", 16'h0000, {15'h0000, alert_oe_out});
		wr(REG_MASK, 16'h0400);
		conv(16'h0080, 16'h0080);
		chk("ready on pin", 16'h0001, {15'h0000, alert_oe_out});
		rd(REG_MASK, rd_val);
		chk("ready flags", 16'h0408, rd_val);
		chk("ready cleared", 16'h0000, {15'h0000, alert_oe_out});
		$display("test latch and ready done");
	endtask : t_latch

	// Inverted polarity pulls the pin while idle; saturation raises the overflow flag.
	task automatic t_polarity();
		wr(REG_MASK, 16'h2002);
		chk("inverted idle", 16'h0001, {15'h0000, alert_oe_out});
		conv(16'h0200, 16'h2000);
		chk("inverted active", 16'h0000, {15'h0000, alert_oe_out});
		wr(REG_CAL, 16'h7FFF);
		conv(16'h7FFF, 16'h0080);
		chk("inverted cleared", 16'h0001, {15'h0000, alert_oe_out});
		rd(REG_CUR, rd_val);
		chk("current saturated", 16'h7FFF, rd_val);
		rd(REG_MASK, rd_val);
		chk("overflow flags", 16'h200E, rd_val);
		$display("test polarity and overflow done");
	endtask : t_polarity

	initial
	begin
		repeat (8) @(posedge clk_in);
		#10;
		rst_in = 1'b0;
		repeat (4) @(posedge clk_in);
		#10;
		t_reset();
		t_results();
		t_limits();
		t_latch();
		t_polarity();
		test_done();
	end

	initial
	begin
		repeat (90000) @(posedge clk_in);
		n_mismatch++;
		test_done();
	end
endmodule : testbench
